// File: mss_defs.vh
// Purpose: Shared constants of the multi-step speed sequencer.
// Assumes: Byte addresses on a 32-bit classic Wishbone slave.
// Notes: Times are in milliseconds and the clock rate in kHz, so products stay below 2**31.
`ifndef MSS_DEFS_VH
`define MSS_DEFS_VH

`define MSS_ADR_CTRL 8'h00
`define MSS_ADR_STAT 8'h04
`define MSS_ADR_SPEED 8'h40
`define MSS_ADR_TIME 8'h80
`define MSS_ADR_BANK_MSB 7
`define MSS_ADR_BANK_LSB 6

`define MSS_CTRL_MODE_LSB 0
`define MSS_CTRL_MODE_MSB 1
`define MSS_CTRL_RETAIN 2
`define MSS_CTRL_UNIT 3
`define MSS_CTRL_PROG_EN 4
`define MSS_CTRL_AUX_SEL 5
`define MSS_CTRL_RESET 6'h00

`define MSS_MODE_ONCE_STOP 2'h0
`define MSS_MODE_ONCE_HOLD 2'h1
`define MSS_MODE_CYCLIC 2'h2

`define MSS_SPEED_MAX 16'sh0BB8
`define MSS_SPEED_MIN (-16'sh0BB8)
`define MSS_SPEED_RESET 16'h0000
`define MSS_TIME_RESET 16'h0000

`define MSS_CLK_KHZ 125000
`define MSS_TENTH_SEC_MS 100
`define MSS_TENTH_MIN_MS 6000
`define MSS_TENTH_SEC_CYC (`MSS_TENTH_SEC_MS * `MSS_CLK_KHZ)
`define MSS_TENTH_MIN_CYC (`MSS_TENTH_MIN_MS * `MSS_CLK_KHZ)

`endif

// File: mss_time_base.v
// Purpose: Divider giving one-cycle ticks of 0.1 s or 0.1 min.
// Assumes: clk_sys_i at 125 MHz.
// Notes: Clearing restarts the tick period so every step gets its full first tenth.
`timescale 1ns/10ps
`default_nettype none
`include "mss_defs.vh"
module mss_time_base #(
  parameter [29:0] TENTH_SEC_CYC = `MSS_TENTH_SEC_CYC,
  parameter [29:0] TENTH_MIN_CYC = `MSS_TENTH_MIN_CYC
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire run_i,
  input wire clear_i,
  input wire unit_min_i,
  output reg tick_o
);
  reg [29:0] cnt_q;
  wire [29:0] last_w = (unit_min_i ? TENTH_MIN_CYC : TENTH_SEC_CYC) - 30'h00000001;

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= 30'h00000000;
      tick_o <= 1'b0;
    end
    else if (clear_i || !run_i)
    begin
      cnt_q <= 30'h00000000;
      tick_o <= 1'b0;
    end
    else if (cnt_q >= last_w)
    begin
      cnt_q <= 30'h00000000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 30'h00000001;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: mss_top.v
// Purpose: Multi-step speed sequencer producing the drive frequency reference.
// Assumes: Synchronous inputs; classic Wishbone register access; speeds in 0.1 % of max frequency.
// Notes: Speeds and references are signed 16-bit values; the rules carried out here follow.
// Operation
// R1: Single-run mode stops after one full cycle.
// R2: Single-run-hold mode keeps final step output.
// R3: Cyclic mode repeats cycles until stop command.
// R4: Retention setting saves stage and frequency across power loss.
// R5: Step speeds are signed, -300.0 to 300.0 percent.
// R6: Step time 0.0 to 6553.5, seconds or minutes.
// R7: Negative step speed runs the motor reverse.
// R8: Program takes each step's stored speed and time.
// R9: Four terminals binary-select one of sixteen speeds.
// R10: All terminals off uses main or auxiliary source.
// R11: Active terminals override all other frequency references.
// R12: Run channel, not selection, starts and stops.
// R13: Step advances when its running time elapses.
// R14: Terminals sampled on clock, selection follows changes.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "mss_defs.vh"
module mss_top #(
  parameter STEPS = 16,
  parameter [29:0] TENTH_SEC_CYC = `MSS_TENTH_SEC_CYC,
  parameter [29:0] TENTH_MIN_CYC = `MSS_TENTH_MIN_CYC
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:0] ms_term_i,
  input wire run_cmd_i,
  input wire stop_cmd_i,
  input wire power_loss_i,
  input wire [15:0] main_ref_i,
  input wire [15:0] aux_ref_i,
  output reg [15:0] freq_ref_o,
  output reg reverse_o,
  output reg running_o,
  output reg multi_step_o,
  output reg [3:0] step_o
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_DOWN = 4'h8;
  localparam integer LAST_INT = STEPS - 1;
  localparam [3:0] LAST_STEP = LAST_INT[3:0];

  reg [5:0] ctrl_q;
  reg [15:0] speed_q [0:STEPS-1];
  reg [15:0] time_q [0:STEPS-1];
  reg [3:0] state_q;
  reg [3:0] pre_state_q;
  reg [3:0] step_q;
  reg [15:0] elapsed_q;
  reg run_q;
  reg [15:0] saved_freq_q;
  reg [3:0] term_q;
  reg [3:0] sel_q;
  reg pwr_q;
  integer i;

  wire [1:0] prog_mode_w = ctrl_q[`MSS_CTRL_MODE_MSB:`MSS_CTRL_MODE_LSB];
  wire retain_w = ctrl_q[`MSS_CTRL_RETAIN];
  wire unit_min_w = ctrl_q[`MSS_CTRL_UNIT];
  wire prog_en_w = ctrl_q[`MSS_CTRL_PROG_EN];
  wire aux_sel_w = ctrl_q[`MSS_CTRL_AUX_SEL];

  wire wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr_w = wb_req_w && wb_we_i;
  wire [1:0] bank_w = wb_adr_i[`MSS_ADR_BANK_MSB:`MSS_ADR_BANK_LSB];
  wire [3:0] idx_w = wb_adr_i[5:2];
  wire [15:0] wr_half_w = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  wire speed_wr_w = wb_wr_w && bank_w == 2'h1 && wb_sel_i[1:0] == 2'h3;
  wire time_wr_w = wb_wr_w && bank_w == 2'h2 && wb_sel_i[1:0] == 2'h3;

  // Out-of-range speeds are clamped on write rather than refused, so a stored value is always legal.
  wire signed [15:0] wr_speed_w = wr_half_w;
  wire [15:0] clamp_w = (wr_speed_w > `MSS_SPEED_MAX) ? `MSS_SPEED_MAX :
                        (wr_speed_w < `MSS_SPEED_MIN) ? `MSS_SPEED_MIN : wr_half_w; // see R5

  wire tick_w;
  wire step_done_w = (elapsed_q >= time_q[step_q]); // see R13
  wire timing_w = (state_q == ST_RUN) && !step_done_w;
  wire restart_w;

  mss_time_base #(
    .TENTH_SEC_CYC(TENTH_SEC_CYC),
    .TENTH_MIN_CYC(TENTH_MIN_CYC)
  ) u_time_base (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .run_i(timing_w),
    .clear_i(restart_w),
    .unit_min_i(unit_min_w), // see R6
    .tick_o(tick_w)
  );

  assign restart_w = (state_q == ST_RUN) && step_done_w;

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q <= `MSS_CTRL_RESET;
      for (i = 0; i < STEPS; i = i + 1)
      begin
        speed_q[i] <= `MSS_SPEED_RESET;
        time_q[i] <= `MSS_TIME_RESET;
      end
    end
    else
    begin
      wb_ack_o <= wb_req_w;
      if (wb_wr_w && wb_adr_i == `MSS_ADR_CTRL && wb_sel_i[0])
        ctrl_q <= wb_dat_i[5:0];
      if (speed_wr_w)
        speed_q[idx_w] <= clamp_w;
      if (time_wr_w)
        time_q[idx_w] <= wr_half_w;
      wb_dat_o <= 32'h00000000;
      if (wb_req_w && !wb_we_i)
      begin
        if (wb_adr_i == `MSS_ADR_CTRL)
          wb_dat_o <= {26'h0000000, ctrl_q};
        else if (wb_adr_i == `MSS_ADR_STAT)
          wb_dat_o <= {16'h0000, saved_freq_q[7:0], state_q, step_q} ^ 32'h00000000;
        else if (bank_w == 2'h1)
          wb_dat_o <= {16'h0000, speed_q[idx_w]};
        else if (bank_w == 2'h2)
          wb_dat_o <= {16'h0000, time_q[idx_w]};
      end
    end
  end

  // Terminal code is taken once per clock; the stored selection follows any change.
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      term_q <= 4'h0;
      sel_q <= 4'h0;
    end
    else
    begin
      term_q <= ms_term_i;
      if (term_q != sel_q)
        sel_q <= term_q; // see R14 R9
    end
  end

  // The run command channel alone starts the drive; a stop command, the end of a single-run program or power loss stops it.
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= ST_IDLE;
      pre_state_q <= ST_IDLE;
      step_q <= 4'h0;
      elapsed_q <= 16'h0000;
      run_q <= 1'b0;
      saved_freq_q <= 16'h0000;
      pwr_q <= 1'b0;
    end
    else
    begin
      pwr_q <= power_loss_i;
      case (state_q)
        ST_IDLE:
        begin
          if (power_loss_i)
          begin
            pre_state_q <= ST_IDLE;
            state_q <= ST_DOWN;
          end
          else if (run_cmd_i && !stop_cmd_i)
          begin
            run_q <= 1'b1; // see R12
            step_q <= 4'h0;
            elapsed_q <= 16'h0000;
            if (prog_en_w)
              state_q <= ST_RUN;
          end
          else if (stop_cmd_i)
            run_q <= 1'b0; // see R12
          else if (run_q && prog_en_w)
          begin
            step_q <= 4'h0;
            elapsed_q <= 16'h0000;
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (power_loss_i)
          begin
            pre_state_q <= ST_RUN;
            saved_freq_q <= speed_q[step_q]; // see R4
            state_q <= ST_DOWN;
          end
          else if (stop_cmd_i || !prog_en_w)
          begin
            run_q <= !stop_cmd_i && run_q;
            state_q <= ST_IDLE; // see R3
          end
          else if (step_done_w)
          begin
            elapsed_q <= 16'h0000;
            if (step_q != LAST_STEP)
              step_q <= step_q + 4'h1; // see R13 R8
            else if (prog_mode_w == `MSS_MODE_CYCLIC)
              step_q <= 4'h0; // see R3
            else if (prog_mode_w == `MSS_MODE_ONCE_HOLD)
              state_q <= ST_HOLD; // see R2
            else
            begin
              run_q <= 1'b0; // see R1
              state_q <= ST_IDLE;
            end
          end
          else if (tick_w)
            elapsed_q <= elapsed_q + 16'h0001;
        end
        ST_HOLD:
        begin
          if (power_loss_i)
          begin
            pre_state_q <= ST_HOLD;
            saved_freq_q <= speed_q[step_q]; // see R4
            state_q <= ST_DOWN;
          end
          else if (stop_cmd_i || !prog_en_w)
          begin
            run_q <= !stop_cmd_i && run_q;
            state_q <= ST_IDLE;
          end
        end
        ST_DOWN:
        begin
          if (!power_loss_i && pwr_q)
          begin
            if (retain_w && pre_state_q != ST_IDLE)
              state_q <= pre_state_q; // see R4
            else
            begin
              state_q <= ST_IDLE;
              run_q <= 1'b0;
              step_q <= 4'h0;
              elapsed_q <= 16'h0000;
              saved_freq_q <= 16'h0000; // see R4
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Terminal selection outranks the program, which outranks the main or auxiliary source.
  reg [15:0] ref_d;
  always @*
  begin
    if (sel_q != 4'h0)
      ref_d = speed_q[sel_q]; // see R11 R9
    else if (state_q == ST_RUN || state_q == ST_HOLD)
      ref_d = speed_q[step_q]; // see R8 R2
    else
      ref_d = aux_sel_w ? aux_ref_i : main_ref_i; // see R10
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      freq_ref_o <= 16'h0000;
      reverse_o <= 1'b0;
      running_o <= 1'b0;
      multi_step_o <= 1'b0;
      step_o <= 4'h0;
    end
    else
    begin
      freq_ref_o <= (run_q && state_q != ST_DOWN) ? ref_d : 16'h0000;
      reverse_o <= run_q && state_q != ST_DOWN && ref_d[15]; // see R7
      running_o <= run_q && state_q != ST_DOWN;
      multi_step_o <= sel_q != 4'h0;
      step_o <= step_q;
    end
  end
endmodule
`default_nettype wire

// File: mss_top_sva.sv
// Purpose: Port checks on the speed sequencer.
// Assumes: One clock, reset active low.
// Notes: Latencies follow the hand-over timing.
`timescale 1ns/10ps
`default_nettype none
module mss_top_sva (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] ms_term_i,
  input wire logic run_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic power_loss_i,
  input wire logic [15:0] freq_ref_o,
  input wire logic reverse_o,
  input wire logic running_o,
  input wire logic multi_step_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_prompt:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_idle_zero:
    assert property (!running_o |-> freq_ref_o == 16'h0000) else $error("speed while stopped");
  a_dir_sign:
    assert property (reverse_o == freq_ref_o[15]) else $error("direction wrong");
  // Three stable samples cover the deepest terminal path.
  a_term_flag:
    assert property ($stable(ms_term_i) [*3] |-> multi_step_o == (ms_term_i != 4'h0)) else $error("flag wrong");
  a_stop_wins:
    assert property (stop_cmd_i |-> ##2 !running_o) else $error("stop ignored");
  a_run_start:
    assert property (run_cmd_i && !stop_cmd_i && !power_loss_i ##1 !stop_cmd_i && !power_loss_i |=> running_o)
      else $error("run ignored");
  a_power_off:
    assert property (power_loss_i [*3] |-> !running_o && freq_ref_o == 16'h0000) else $error("output in loss");
endmodule
bind mss_top mss_top_sva u_mss_top_sva (
  .clk_sys_i(clk_sys_i),
  .rst_b_i(rst_b_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .ms_term_i(ms_term_i),
  .run_cmd_i(run_cmd_i),
  .stop_cmd_i(stop_cmd_i),
  .power_loss_i(power_loss_i),
  .freq_ref_o(freq_ref_o),
  .reverse_o(reverse_o),
  .running_o(running_o),
  .multi_step_o(multi_step_o)
);
`default_nettype wire

// File: mss_drv.sv
// Purpose: Terminals and run channel facing the sequencer.
// Assumes: Driven only from the bench's tasks.
// Notes: Commands are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module mss_drv (
  input wire logic clk_sys_i,
  output logic [3:0] ms_term_o,
  output logic run_cmd_o,
  output logic stop_cmd_o
);
  initial {ms_term_o, run_cmd_o, stop_cmd_o} = 6'h00;
  // Binary code with terminal 1 in bit 0; zero hands back to the main or auxiliary source.
  task automatic set_code(input logic [3:0] c);
    @(posedge clk_sys_i);
    ms_term_o <= c;
  endtask
  // Start and stop come from the run channel alone.
  task automatic pulse(input logic stop);
    @(posedge clk_sys_i);
    {run_cmd_o, stop_cmd_o} <= {!stop, stop};
    @(posedge clk_sys_i);
    {run_cmd_o, stop_cmd_o} <= 2'h0;
  endtask
endmodule
`default_nettype wire

// File: mss_top_tb.sv
// Purpose: Self-checking bench of the speed sequencer.
// Assumes: A tenth lasts 10 cycles, or 20 in minutes.
// Notes: Step 0 runs two tenths, all other steps zero time.
`timescale 1ns/10ps
`default_nettype none
module mss_top_tb;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic power_loss_i = 1'b0;
  logic [15:0] main_ref_i = 16'h0123;
  logic [15:0] aux_ref_i = 16'hFE00;
  wire logic [31:0] wb_dat_o;
  wire logic [15:0] freq_ref_o;
  wire logic [3:0] ms_term_i, step_o;
  wire logic wb_ack_o, run_cmd_i, stop_cmd_i, reverse_o, running_o, multi_step_o;
  logic [31:0] rd_q;
  int failures = 0;
  int check_count = 0;
  mss_top #(.TENTH_SEC_CYC(30'hA), .TENTH_MIN_CYC(30'h14)) u_mss_top (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ms_term_i(ms_term_i), .run_cmd_i(run_cmd_i), .stop_cmd_i(stop_cmd_i), .power_loss_i(power_loss_i),
    .main_ref_i(main_ref_i), .aux_ref_i(aux_ref_i), .freq_ref_o(freq_ref_o), .reverse_o(reverse_o),
    .running_o(running_o), .multi_step_o(multi_step_o), .step_o(step_o)
  );
  mss_drv u_mss_drv (.clk_sys_i(clk_sys_i), .ms_term_o(ms_term_i), .run_cmd_o(run_cmd_i), .stop_cmd_o(stop_cmd_i));
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  function automatic logic [15:0] spd(input int i);
    return 16'(i * 100 - 700);
  endfunction
  // Values read just after an edge are those the edge sampled.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel = 4'hF);
    @(posedge clk_sys_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'h3, we, sel, adr, dat};
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic s_regs();
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", rd_q, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped", rd_q, 32'h0);
    wb(1'b1, 8'h44, 32'h1000);
    wb(1'b0, 8'h44, 32'h0);
    chk("clamp high", rd_q, 32'hBB8);
    wb(1'b1, 8'h44, 32'hF000);
    wb(1'b0, 8'h44, 32'h0);
    chk("clamp low", rd_q, 32'hF448);
    for (int i = 0; i < 16; i++)
    begin
      wb(1'b1, 8'(8'h40 + 4 * i), {16'h0, spd(i)});
      wb(1'b1, 8'(8'h80 + 4 * i), (i == 0) ? 32'h2 : 32'h0);
    end
    wb(1'b1, 8'h48, 32'h0055, 4'h1);
    wb(1'b0, 8'h48, 32'h0);
    chk("sel refused", rd_q, {16'h0, spd(2)});
    wb(1'b0, 8'h80, 32'h0);
    chk("time", rd_q, 32'h2);
  endtask
  task automatic s_terms();
    wb(1'b1, 8'h00, 32'h0);
    u_mss_drv.pulse(1'b0);
    for (int c = 1; c < 16; c++)
    begin
      u_mss_drv.set_code(4'(c));
      cy(5);
      chk("term speed", freq_ref_o, spd(c));
      chk("term dir", reverse_o, c < 7);
      chk("term flag", multi_step_o, 1'b1);
    end
    main_ref_i <= 16'h0456;
    u_mss_drv.set_code(4'h0);
    cy(5);
    chk("main ref", freq_ref_o, main_ref_i);
    chk("term off", multi_step_o, 1'b0);
    aux_ref_i <= 16'hFC18;
    wb(1'b1, 8'h00, 32'h20);
    cy(3);
    chk("aux ref", freq_ref_o, aux_ref_i);
    u_mss_drv.pulse(1'b1);
    cy(4);
    chk("term stop", running_o, 1'b0);
  endtask
  task automatic s_prog(input logic [1:0] mode, input logic unit);
    int n;
    wb(1'b1, 8'h00, {27'h1, unit, 1'b0, mode});
    u_mss_drv.pulse(1'b0);
    for (int k = 0; k < 50 && running_o !== 1'b1; k++) @(posedge clk_sys_i);
    chk("prog speed", freq_ref_o, spd(0));
    chk("prog dir", reverse_o, 1'b1);
    for (n = 0; n < 99 && step_o === 4'h0; n++) @(posedge clk_sys_i);
    chk("step time", n >= (unit ? 39 : 19) && n <= (unit ? 44 : 24), 32'h1);
    for (int k = 0; k < 200 && step_o !== 4'hF; k++) @(posedge clk_sys_i);
    cy(6);
    if (mode == 2'h0 || mode == 2'h3)
      chk("once stop", {running_o, freq_ref_o}, 32'h0);
    else if (mode == 2'h1)
      chk("once hold", {running_o, freq_ref_o}, {1'b1, spd(15)});
    else
      chk("cyclic", {running_o, freq_ref_o}, {1'b1, spd(0)});
    if (mode == 2'h1)
    begin
      wb(1'b0, 8'h04, 32'h0);
      chk("stat hold", rd_q, 32'h4F);
    end
    u_mss_drv.pulse(1'b1);
    cy(4);
    chk("stopped", running_o, 1'b0);
  endtask
  task automatic s_power();
    wb(1'b1, 8'h00, 32'h16);
    u_mss_drv.pulse(1'b0);
    cy(9);
    power_loss_i <= 1'b1;
    cy(4);
    chk("loss", {running_o, freq_ref_o}, 32'h0);
    power_loss_i <= 1'b0;
    cy(5);
    chk("kept", {running_o, freq_ref_o}, {1'b1, spd(0)});
    wb(1'b1, 8'h00, 32'h12);
    power_loss_i <= 1'b1;
    cy(4);
    power_loss_i <= 1'b0;
    cy(5);
    chk("forgot", running_o, 1'b0);
  endtask
  // A second reset while stopped must clear the settings and the step memory.
  task automatic s_reset();
    rst_b_i <= 1'b0;
    cy(3);
    chk("reset out", {running_o, freq_ref_o}, 32'h0);
    rst_b_i <= 1'b1;
    wb(1'b0, 8'h44, 32'h0);
    chk("reset speed", rd_q, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk("reset ctrl", rd_q, 32'h0);
  endtask
  initial
  begin
    cy(3);
    rst_b_i <= 1'b1;
    s_regs();
    s_terms();
    s_prog(2'h0, 1'b0);
    s_prog(2'h1, 1'b1);
    s_prog(2'h2, 1'b0);
    s_prog(2'h3, 1'b0);
    s_power();
    s_reset();
    tally_and_finish();
  end
  initial
  begin
    cy(20000);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
